// ### hw/rsq_reset_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "rsq_defines.svh"
// Notes on behaviour
// - Reset requests come from the reset pin, the low voltage detector and the watchdog.
// - An illegal opcode or prebyte seen in decode also starts a reset sequence.
// - Every source pulls the reset pin, and the pin stays low through the whole delay.
// - After the delay the vector is fetched from the pair FFFEh and FFFFh.
// - A sequence runs active phase, then stabilisation delay, then vector fetch.
// - The delay is 256 or 4096 cycles, picked from the clock source in the option byte.
// - The vector fetch lasts exactly two clock cycles before the routine starts.
// - A crystal or resonator oscillator keeps running all through reset.
// - In communication mode the dedicated system memory vector is fetched instead.
// - A low pulse on the reset pin is caught without a clock, even with clocks halted.
// - The reset pin is an input and an open-drain output with a weak pull-up.
module rsq_reset_sequencer #(
    parameter logic [12:0] DELAY_LONG  = `RSQ_DELAY_LONG,
    parameter logic [12:0] DELAY_SHORT = `RSQ_DELAY_SHORT,
    parameter logic [7:0]  ACTIVE_LEN  = `RSQ_ACTIVE_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        reset_pin_in,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    input  wire logic        low_voltage_detector,
    input  wire logic        watchdog_reset,
    input  wire logic        illegal_opcode,
    input  wire logic        illegal_prebyte,
    input  wire logic        opt_crystal_clock,
    input  wire logic        in_circuit_comm_mode,
    output logic             osc_keep_running,
    output logic             core_reset,
    output logic             vec_fetch,
    output logic [15:0]      vec_addr,
    output logic             exec_start
);
    rsq_pkg::rsq_state_e state_q;
    rsq_pkg::rsq_src_s   src;
    logic [1:0]  pin_sync_q;
    logic        pin_async_q;
    logic        pin_latch_s1_q;
    logic        pin_latch_s2_q;
    logic [12:0] cnt_q;
    logic        any_req;
    logic        comm_q;
    logic [1:0]  own_drive_q;

    // Pin low is caught by a clockless latch-style flop so a halted clock loses nothing
    always_ff @(negedge reset_pin_in or posedge pin_latch_s2_q) begin
        if (pin_latch_s2_q) begin
            pin_async_q <= 1'b0;
        end else begin
            pin_async_q <= 1'b1;
        end
    end

    // Two-flop sync of the captured event and of the pin level
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_latch_s1_q <= 1'b0;
            pin_latch_s2_q <= 1'b0;
            pin_sync_q     <= 2'h3;
        end else if (clk_en) begin
            pin_latch_s1_q <= pin_async_q;
            pin_latch_s2_q <= pin_latch_s1_q;
            pin_sync_q     <= {pin_sync_q[0], reset_pin_in};
        end
    end

    // Our own pull reaches the pin input too; remember it until the synchroniser sees release
    always_ff @(posedge clock) begin
        if (rst) begin
            own_drive_q <= 2'h3;
        end else if (clk_en) begin
            own_drive_q <= {own_drive_q[0], reset_pin_oe};
        end
    end

    // Gather every source into one request
    // Limitation: an outside pulse while we pull is merged with our own pull; a pin
    // still held low once we let go is caught and restarts the sequence
    always_comb begin
        src.pin_low     = (pin_latch_s2_q | ~pin_sync_q[1]) &
                          ~(reset_pin_oe | (|own_drive_q));
        src.low_voltage = low_voltage_detector;
        src.watchdog    = watchdog_reset;
        src.illegal_op  = illegal_opcode | illegal_prebyte;
        any_req         = |src;
    end

    // Sequencer: a request always re-enters the active phase with a fresh count
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= rsq_pkg::RSQ_ACTIVE;
            cnt_q   <= 13'h0000;
        end else if (clk_en) begin
            if (any_req) begin
                state_q <= rsq_pkg::RSQ_ACTIVE;
                cnt_q   <= {5'h00, ACTIVE_LEN};
            end else begin
                unique case (state_q)
                    rsq_pkg::RSQ_IDLE: begin
                        cnt_q <= 13'h0000;
                    end
                    rsq_pkg::RSQ_ACTIVE: begin
                        if (cnt_q <= 13'h0001) begin
                            state_q <= rsq_pkg::RSQ_DELAY;
                            // Crystal needs the long settling time
                            cnt_q   <= opt_crystal_clock ? DELAY_LONG : DELAY_SHORT;
                        end else begin
                            cnt_q <= cnt_q - 13'h0001;
                        end
                    end
                    rsq_pkg::RSQ_DELAY: begin
                        if (cnt_q == 13'h0001) begin
                            state_q <= rsq_pkg::RSQ_FETCH;
                            cnt_q   <= {11'h000, `RSQ_FETCH_CYCLES};
                        end else begin
                            cnt_q <= cnt_q - 13'h0001;
                        end
                    end
                    rsq_pkg::RSQ_FETCH: begin
                        if (cnt_q == 13'h0001) begin
                            state_q <= rsq_pkg::RSQ_IDLE;
                        end
                        cnt_q <= cnt_q - 13'h0001;
                    end
                    default: begin
                        state_q <= rsq_pkg::RSQ_ACTIVE;
                        cnt_q   <= 13'h0000;
                    end
                endcase
            end
        end
    end

    // Mode is latched while reset is held so the tool sequence decides the vector
    always_ff @(posedge clock) begin
        if (rst) begin
            comm_q <= 1'b0;
        end else if (clk_en && state_q != rsq_pkg::RSQ_FETCH && state_q != rsq_pkg::RSQ_IDLE) begin
            comm_q <= in_circuit_comm_mode;
        end
    end

    // Vector address, registered one cycle late: low byte in the second fetch cycle, then high after the fetch
    always_ff @(posedge clock) begin
        if (rst) begin
            vec_addr <= 16'h0000;
        end else if (clk_en) begin
            if (state_q == rsq_pkg::RSQ_FETCH && cnt_q == 13'h0002) begin
                vec_addr <= comm_q ? `RSQ_SYS_VEC_ADDR_LO : `RSQ_VEC_ADDR_LO;
            end else if (state_q == rsq_pkg::RSQ_FETCH) begin
                vec_addr <= comm_q ? `RSQ_SYS_VEC_ADDR_HI : `RSQ_VEC_ADDR_HI;
            end
        end
    end

    // Open drain: only ever drive low; the pull-up lives in the pad
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = (state_q == rsq_pkg::RSQ_ACTIVE) ||
                           (state_q == rsq_pkg::RSQ_DELAY);
    assign core_reset    = (state_q != rsq_pkg::RSQ_IDLE);
    assign vec_fetch     = (state_q == rsq_pkg::RSQ_FETCH);
    assign exec_start    = (state_q == rsq_pkg::RSQ_FETCH) && (cnt_q == 13'h0001);
    assign osc_keep_running = opt_crystal_clock;

    AST_PIN_LOW_IN_DELAY: assert property (@(posedge clock) disable iff (rst)
        (state_q == rsq_pkg::RSQ_DELAY) |-> (reset_pin_oe && !reset_pin_out))
        else $error("reset pin released during delay");

    sequence s_fetch_first;
        vec_fetch && !exec_start;
    endsequence
    sequence s_fetch_last;
        vec_fetch && exec_start;
    endsequence
    AST_FETCH_TWO: assert property (@(posedge clock) disable iff (rst)
        ($rose(vec_fetch) && clk_en && !any_req) |-> s_fetch_first ##1 s_fetch_last)
        else $error("fetch not two cycles");
    AST_FETCH_LEN: assert property (@(posedge clock) disable iff (rst)
        (clk_en && exec_start && !any_req) |=> (!vec_fetch && !core_reset))
        else $error("fetch ran past two cycles");
    AST_RESTART: assert property (@(posedge clock) disable iff (rst)
        (clk_en && any_req) |=> (state_q == rsq_pkg::RSQ_ACTIVE && cnt_q == {5'h00, ACTIVE_LEN}))
        else $error("request did not restart sequence");
    AST_DELAY_LOAD: assert property (@(posedge clock) disable iff (rst)
        (clk_en && !any_req && state_q == rsq_pkg::RSQ_ACTIVE && cnt_q <= 13'h0001) |=>
        (state_q == rsq_pkg::RSQ_DELAY) &&
        (cnt_q == ($past(opt_crystal_clock) ? DELAY_LONG : DELAY_SHORT)))
        else $error("wrong delay length");
    AST_ORDER: assert property (@(posedge clock) disable iff (rst)
        $rose(vec_fetch) |-> $past(state_q == rsq_pkg::RSQ_DELAY))
        else $error("fetch not after delay");
    AST_VEC_NORMAL: assert property (@(posedge clock) disable iff (rst)
        (clk_en && vec_fetch && cnt_q == 13'h0002 && !comm_q) |=> vec_addr == `RSQ_VEC_ADDR_LO)
        else $error("wrong reset vector");
    AST_VEC_COMM: assert property (@(posedge clock) disable iff (rst)
        (clk_en && vec_fetch && cnt_q == 13'h0002 && comm_q) |=> vec_addr == `RSQ_SYS_VEC_ADDR_LO)
        else $error("wrong system vector");
    AST_SRC_WDG: assert property (@(posedge clock) disable iff (rst)
        (clk_en && (watchdog_reset || low_voltage_detector)) |=> reset_pin_oe)
        else $error("source did not pull pin");
endmodule : rsq_reset_sequencer
`default_nettype wire

// ### hw/rsq_defines.svh
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH
`define RSQ_DELAY_SHORT      13'h0100
`define RSQ_DELAY_LONG       13'h1000
`define RSQ_FETCH_CYCLES     2'h2
`define RSQ_ACTIVE_CYCLES    8'h08
`define RSQ_VEC_ADDR_LO      16'hfffe
`define RSQ_VEC_ADDR_HI      16'hffff
`define RSQ_SYS_VEC_ADDR_LO  16'h1ffe
`define RSQ_SYS_VEC_ADDR_HI  16'h1fff
`endif

// ### hw/rsq_pkg.sv
package rsq_pkg;
    typedef enum logic [3:0] {
        RSQ_IDLE   = 4'b0001,
        RSQ_ACTIVE = 4'b0010,
        RSQ_DELAY  = 4'b0100,
        RSQ_FETCH  = 4'b1000
    } rsq_state_e;
    typedef struct packed {
        logic pin_low;
        logic low_voltage;
        logic watchdog;
        logic illegal_op;
    } rsq_src_s;
endpackage : rsq_pkg

// ### dv/rsq_prog_tool.sv
`timescale 1ns/1ns
`default_nettype none
// Reset circuit and programming tool that sit on the far side of the reset pin
module rsq_prog_tool (
    input  wire logic clock,
    input  wire logic hold_low,
    input  wire logic comm_req,
    input  wire logic pin_oe,
    input  wire logic pin_out,
    output logic      pin_level,
    output logic      comm_mode
);
    // Open drain wire: any party pulls it low, otherwise the weak pull-up wins
    assign pin_level = ((pin_oe && !pin_out) || hold_low) ? 1'b0 : 1'b1;
    // Tool claims the link when it holds the pin low and keeps it until comm_req drops, so a blank part never runs
    initial comm_mode = 1'b0;
    always @(posedge clock) begin
        if (!comm_req) begin
            comm_mode <= 1'b0;
        end else if (hold_low) begin
            comm_mode <= 1'b1;
        end
    end
endmodule : rsq_prog_tool
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "rsq_defines.svh"
module testbench;
    localparam logic [12:0] D_LONG = 13'h0010;
    logic        clock, rst, clk_en, lv_req, wd_req, opc_req, pre_req, xtal, hold_low, comm_req;
    logic        pin_level, comm_mode, pin_out, pin_oe, osc_run, core_reset, vec_fetch, exec_start;
    logic [15:0] vec_addr;
    int          err_count = 0, samples_checked = 0, cycles = 0, len_long, len_short, len;
    // Long delay shortened so the crystal case stays quick
    rsq_reset_sequencer #(.DELAY_LONG(D_LONG)) dut (.clock(clock), .rst(rst), .clk_en(clk_en),
        .reset_pin_in(pin_level), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
        .low_voltage_detector(lv_req), .watchdog_reset(wd_req), .illegal_opcode(opc_req),
        .illegal_prebyte(pre_req), .opt_crystal_clock(xtal), .in_circuit_comm_mode(comm_mode),
        .osc_keep_running(osc_run), .core_reset(core_reset), .vec_fetch(vec_fetch),
        .vec_addr(vec_addr), .exec_start(exec_start));
    rsq_prog_tool tool (.clock(clock), .hold_low(hold_low), .comm_req(comm_req), .pin_oe(pin_oe),
        .pin_out(pin_out), .pin_level(pin_level), .comm_mode(comm_mode));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Hang guard, far above the several hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic step();
        @(posedge clock);
        #1;
    endtask : step
    task automatic set_src(input int s, input logic v);
        case (s)
            0: hold_low <= v;
            1: lv_req <= v;
            2: wd_req <= v;
            3: opc_req <= v;
            default: pre_req <= v;
        endcase
    endtask : set_src
    // Counts cycles from release to fetch, then judges the fetch and the idle state
    task automatic finish_seq(input logic [15:0] lo, input logic [15:0] hi, output int n);
        int f;
        int e;
        n = 0;
        f = 0;
        e = 0;
        step();
        while (vec_fetch !== 1'b1 && n < 6000) begin
            chk("pin_oe", 16'(pin_oe), 16'h0001);
            chk("core_reset", 16'(core_reset), 16'h0001);
            step();
            n++;
        end
        while (vec_fetch === 1'b1 && f < 4) begin
            if (exec_start === 1'b1) begin
                e++;
                chk("vec_lo", vec_addr, lo);
            end
            f++;
            step();
        end
        chk("fetch_len", 16'(f), 16'h0002);
        chk("exec_pulses", 16'(e), 16'h0001);
        chk("vec_hi", vec_addr, hi);
        chk("pin_oe_idle", 16'(pin_oe), 16'h0000);
        chk("osc_run", 16'(osc_run), 16'(xtal));
    endtask : finish_seq
    task automatic run_seq(input int s, input logic x, input logic comm, output int n);
        @(posedge clock);
        xtal <= x;
        comm_req <= comm;
        set_src(s, 1'b1);
        repeat (3) @(posedge clock);
        set_src(s, 1'b0);
        finish_seq(comm ? `RSQ_SYS_VEC_ADDR_LO : `RSQ_VEC_ADDR_LO,
                   comm ? `RSQ_SYS_VEC_ADDR_HI : `RSQ_VEC_ADDR_HI, n);
        @(posedge clock);
        comm_req <= 1'b0;
        $display("test source %0d done", s);
    endtask : run_seq
    // Second request lands mid-delay; the whole sequence must be rerun from there
    task automatic restart_test();
        int n;
        @(posedge clock);
        xtal <= 1'b1;
        wd_req <= 1'b1;
        repeat (3) @(posedge clock);
        wd_req <= 1'b0;
        repeat (14) @(posedge clock);
        lv_req <= 1'b1;
        repeat (3) @(posedge clock);
        lv_req <= 1'b0;
        finish_seq(`RSQ_VEC_ADDR_LO, `RSQ_VEC_ADDR_HI, n);
        chk("restart_len", 16'(n), 16'(len_long));
        $display("test restart done");
    endtask : restart_test
    // Pin pulse while the clock enable is low must be kept and acted on later
    task automatic halt_test();
        int n;
        @(posedge clock);
        clk_en <= 1'b0;
        @(posedge clock);
        hold_low <= 1'b1;
        @(posedge clock);
        hold_low <= 1'b0;
        @(posedge clock);
        chk("frozen", 16'(core_reset), 16'h0000);
        clk_en <= 1'b1;
        repeat (3) @(posedge clock);
        finish_seq(`RSQ_VEC_ADDR_LO, `RSQ_VEC_ADDR_HI, n);
        chk("halt_len", 16'(n), 16'(len_long));
        $display("test halt done");
    endtask : halt_test
    initial begin
        {rst, clk_en, xtal} = 3'b111;
        {lv_req, wd_req, opc_req, pre_req, hold_low, comm_req} = 6'h00;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        finish_seq(`RSQ_VEC_ADDR_LO, `RSQ_VEC_ADDR_HI, len);
        run_seq(1, 1'b1, 1'b0, len_long);
        run_seq(1, 1'b0, 1'b0, len_short);
        chk("delay_diff", 16'(len_short - len_long), 16'(`RSQ_DELAY_SHORT - D_LONG));
        for (int s = 0; s < 5; s++) begin
            run_seq(s, 1'b1, 1'b0, len);
            chk("src_len", 16'(len), 16'(len_long));
        end
        run_seq(0, 1'b1, 1'b1, len);
        restart_test();
        halt_test();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
